// >>> pkg/rlc_map.svh
// Register offsets, reset values and timing figures for the record level control.
// Assumes inclusion by the design and bench files; definitions only.
`ifndef RLC_MAP_SVH
`define RLC_MAP_SVH
`define RLC_OFS_CFG_A   7'h7b
`define RLC_OFS_CFG_B   7'h7c
`define RLC_OFS_RESTART 7'h7d
`define RLC_RST_CFG     8'h00
`define RLC_RST_GAIN    8'h00
`define RLC_MAX_GAIN    8'hff
// Timing figures in their own unit, then derived base counts
`define RLC_CLK_MHZ     200
`define RLC_MS_CYCLES   (`RLC_CLK_MHZ * 1000)
`define RLC_ATK_MS_0    1
`define RLC_ATK_MS_1    4
`define RLC_REL_MS_BASE 32
// Level codes: full scale 0 dB as 16'h7fff, thresholds as linear amplitudes
`define RLC_DB_0        16'h7fff
`define RLC_DB_M1       16'h7214
`define RLC_DB_M2       16'h65ac
`define RLC_DB_M3       16'h5a9d
`define RLC_DB_M4       16'h50c3
`define RLC_DB_M6       16'h4026
`endif

// >>> pkg/rlc_pkg.sv
// Types for the record level control block.
// Assumes the map header sits beside it.
package rlc_pkg;
  typedef enum logic [1:0] {RLC_POL_NONE = 2'h0, RLC_POL_NORMAL = 2'h1,
                            RLC_POL_LIMITED = 2'h2, RLC_POL_RSVD = 2'h3} rlc_policy_e;
  typedef enum logic [1:0] {RLC_ST_IDLE = 2'h0, RLC_ST_ATTACK = 2'h1,
                            RLC_ST_RELEASE = 2'h3} rlc_state_e;
  typedef struct packed {
    logic [1:0]  adc_rate_select;
    logic [1:0]  recovery_step_cap;
    rlc_policy_e recovery_policy;
    logic        channel_trigger_policy;
    logic        level_control_on;
  } rlc_cfg_a_s;
  typedef struct packed {
    logic       rsvd;
    logic [1:0] release_threshold;
    logic [1:0] attack_threshold;
    logic [1:0] release_step_period;
    logic       attack_period;
  } rlc_cfg_b_s;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [7:0]  wdata;
  } rlc_reg_req_s;
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
    logic        valid;
  } rlc_sample_s;
endpackage

// >>> design/rlc_tick_div.sv
// Programmable divider giving one-cycle enable pulses.
// Assumes a synchronous active-high reset and a load-free period input.
module rlc_tick_div #(
  parameter int W = 27
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_clr,
  input  wire logic [W-1:0] i_period,
  output logic              o_tick
);
  logic [W-1:0] cnt_q;
  initial begin
    if (W < 2) $error("rlc_tick_div: width too small");
  end
  // Count up to period-1, pulse and wrap; clear restarts the phase
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clr || o_tick) cnt_q <= '0;
    else cnt_q <= cnt_q + W'(1);
  end
  assign o_tick = (cnt_q >= i_period - W'(1)) && !i_clr;
endmodule

// >>> design/rlc_level_ctrl.sv
// Record channel automatic level control with its three control registers.
// Assumes samples and register strobes arrive on the core clock domain.
`include "rlc_map.svh"
module rlc_level_ctrl
  import rlc_pkg::*;
#(
  parameter int ATK_W = 20,
  parameter int REL_W = 27,
  parameter int MS_CYCLES = `RLC_MS_CYCLES
) (
  input  wire logic                 I_CORE_CLK,
  input  wire logic                 I_RST,
  input  wire rlc_pkg::rlc_reg_req_s i_req,
  input  wire rlc_pkg::rlc_sample_s  i_sample,
  output logic [7:0]                o_rdata,
  output logic [7:0]                o_gain_reduction,
  output logic                      o_crystal_run,
  output logic                      o_rx_osc_run
);
  import rlc_pkg::*;

  initial begin
    if (MS_CYCLES < 1) $error("rlc_level_ctrl: bad ms count");
    if (64'(MS_CYCLES) * 256 >= (64'd1 << REL_W)) $error("rlc_level_ctrl: REL_W too small");
    if (64'(MS_CYCLES) * 4 >= (64'd1 << ATK_W)) $error("rlc_level_ctrl: ATK_W too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  rlc_cfg_a_s cfg_a_q;
  rlc_cfg_b_s cfg_b_q;
  logic [7:0] gain_q;
  logic [4:0] steps_q;
  logic [7:0] rdata_q;
  wire wr_a   = i_req.wr && (i_req.addr == `RLC_OFS_CFG_A);
  wire wr_b   = i_req.wr && (i_req.addr == `RLC_OFS_CFG_B);
  wire restart = i_req.wr && (i_req.addr == `RLC_OFS_RESTART);

  // Config registers; reserved rate code is stored as written, software owns it
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      cfg_a_q <= `RLC_RST_CFG;
      cfg_b_q <= `RLC_RST_CFG;
    end else begin
      if (wr_a) cfg_a_q <= i_req.wdata;
      if (wr_b) cfg_b_q <= {1'b0, i_req.wdata[6:0]};
    end
  end

  wire [7:0] rd_mux = (i_req.addr == `RLC_OFS_CFG_A)   ? cfg_a_q :
                      (i_req.addr == `RLC_OFS_CFG_B)   ? cfg_b_q :
                      (i_req.addr == `RLC_OFS_RESTART) ? gain_q  : 8'h00;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) rdata_q <= 8'h00;
    else if (i_req.rd) rdata_q <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold decode, shared by both thresholds
  function automatic logic [15:0] thr_lvl(input logic [1:0] code, input logic is_rel);
    case ({is_rel, code})
      3'h0: thr_lvl = `RLC_DB_0;
      3'h1: thr_lvl = `RLC_DB_M1;
      3'h2: thr_lvl = `RLC_DB_M2;
      3'h3: thr_lvl = `RLC_DB_M4;
      3'h4: thr_lvl = `RLC_DB_M2;
      3'h5: thr_lvl = `RLC_DB_M3;
      3'h6: thr_lvl = `RLC_DB_M4;
      default: thr_lvl = `RLC_DB_M6;
    endcase
  endfunction

  function automatic logic [15:0] mag(input logic [15:0] s);
    mag = s[15] ? (~s + 16'h0001) : s;
  endfunction

  wire [15:0] atk_lvl = thr_lvl(cfg_b_q.attack_threshold, 1'b0);
  wire [15:0] rel_lvl = thr_lvl(cfg_b_q.release_threshold, 1'b1);
  wire [15:0] mag_l = mag(i_sample.left);
  wire [15:0] mag_r = mag(i_sample.right);
  wire over_l = mag_l >= atk_lvl;
  wire over_r = mag_r >= atk_lvl;
  wire over  = cfg_a_q.channel_trigger_policy ? (over_l && over_r) : (over_l || over_r);
  wire below = (mag_l < rel_lvl) && (mag_r < rel_lvl);

  ////////////////////////////////////////////////////////////////////////////
  // Timers: attack and release step enables
  // attack period select
  wire [ATK_W-1:0] atk_per = ATK_W'(MS_CYCLES * (cfg_b_q.attack_period ? `RLC_ATK_MS_1
                                                                      : `RLC_ATK_MS_0));
  wire [REL_W-1:0] rel_per = REL_W'(MS_CYCLES * (`RLC_REL_MS_BASE
                                                  << cfg_b_q.release_step_period));
  logic atk_tick;
  logic rel_tick;
  logic hot_q;
  logic quiet_q;
  rlc_tick_div #(.W(ATK_W)) u_atk (
    .i_clk    (I_CORE_CLK),
    .i_rst    (I_RST),
    .i_clr    (restart),
    .i_period (atk_per),
    .o_tick   (atk_tick)
  );
  rlc_tick_div #(.W(REL_W)) u_rel (
    .i_clk    (I_CORE_CLK),
    .i_rst    (I_RST),
    .i_clr    (restart),
    .i_period (rel_per),
    .o_tick   (rel_tick)
  );

  // Level memory per period: any hot sample in an attack period, all quiet in release
  // A sample on a tick edge opens the next period, so it is never dropped
  logic hot_any_q;
  logic quiet_all_q;
  wire  hot_now  = i_sample.valid && over;
  wire  loud_now = i_sample.valid && !below;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || restart) hot_any_q <= 1'b0;
    else if (atk_tick) hot_any_q <= hot_now;
    else if (hot_now) hot_any_q <= 1'b1;
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || restart) quiet_all_q <= 1'b1;
    else if (rel_tick) quiet_all_q <= !loud_now;
    else if (loud_now) quiet_all_q <= 1'b0;
  end
  assign hot_q   = hot_any_q;
  assign quiet_q = quiet_all_q;

  ////////////////////////////////////////////////////////////////////////////
  // Gain control state machine
  rlc_state_e st_q;
  rlc_state_e st_d;
  wire [4:0] cap_lim = 5'((6'h04 << cfg_a_q.recovery_step_cap) - 6'h01);
  wire rec_ok = (cfg_a_q.recovery_policy == RLC_POL_NORMAL) ||
                ((cfg_a_q.recovery_policy == RLC_POL_LIMITED) && (steps_q < cap_lim));
  wire do_atk = cfg_a_q.level_control_on && atk_tick && hot_q && (gain_q != `RLC_MAX_GAIN);
  wire do_rel = cfg_a_q.level_control_on && rel_tick && quiet_q && rec_ok && !do_atk &&
                (gain_q != 8'h00);

  always_comb begin
    st_d = st_q;
    case (st_q)
      RLC_ST_IDLE:    if (do_atk) st_d = RLC_ST_ATTACK;
      RLC_ST_ATTACK:  if (do_rel) st_d = RLC_ST_RELEASE;
      RLC_ST_RELEASE: if (do_atk) st_d = RLC_ST_ATTACK;
                      else if (gain_q == 8'h01 && do_rel) st_d = RLC_ST_IDLE;
      default:        st_d = RLC_ST_IDLE;
    endcase
  end

  // off clears reduction; restart also clears
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || restart || !cfg_a_q.level_control_on) begin
      st_q   <= RLC_ST_IDLE;
      gain_q <= `RLC_RST_GAIN;
    end else begin
      st_q <= st_d;
      if (do_atk) gain_q <= gain_q + 8'h01;
      else if (do_rel) gain_q <= gain_q - 8'h01;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || restart) steps_q <= 5'h00;
    else if (do_rel && cfg_a_q.recovery_policy == RLC_POL_LIMITED) steps_q <= steps_q + 5'h01;
  end

  assign o_rdata          = rdata_q;
  assign o_gain_reduction = gain_q;
  assign o_crystal_run = 1'b1;
  assign o_rx_osc_run  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_off_zero;
    @(posedge I_CORE_CLK) disable iff (I_RST)
    !cfg_a_q.level_control_on |=> gain_q == 8'h00;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("reduction while off");
  property p_restart;
    @(posedge I_CORE_CLK) disable iff (I_RST)
    restart |=> gain_q == 8'h00 && steps_q == 5'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear");
  property p_read;
    @(posedge I_CORE_CLK) disable iff (I_RST)
    i_req.rd && i_req.addr == `RLC_OFS_RESTART |=> o_rdata == $past(gain_q);
  endproperty
  a_read: assert property (p_read) else $error("read not gain");
  property p_norec;
    @(posedge I_CORE_CLK) disable iff (I_RST)
    cfg_a_q.recovery_policy == RLC_POL_NONE && cfg_a_q.level_control_on && !restart
    |=> gain_q >= $past(gain_q);
  endproperty
  a_norec: assert property (p_norec) else $error("recovered in no-recovery");
  property p_cap;
    @(posedge I_CORE_CLK) disable iff (I_RST)
    cfg_a_q.recovery_policy == RLC_POL_LIMITED && steps_q <= cap_lim && !wr_a
    |=> steps_q <= cap_lim;
  endproperty
  a_cap: assert property (p_cap) else $error("step cap exceeded");
  property p_step;
    @(posedge I_CORE_CLK) disable iff (I_RST)
    !restart && cfg_a_q.level_control_on && !atk_tick && !rel_tick |=> $stable(gain_q);
  endproperty
  a_step: assert property (p_step) else $error("gain moved off tick");
  property p_stop;
    @(posedge I_CORE_CLK) disable iff (I_RST)
    cfg_a_q.recovery_policy == RLC_POL_LIMITED && cfg_a_q.level_control_on &&
    steps_q == cap_lim && !do_atk && !restart
    |=> gain_q == $past(gain_q);
  endproperty
  a_stop: assert property (p_stop) else $error("recovered past cap");
  property p_trig;
    @(posedge I_CORE_CLK) disable iff (I_RST)
    cfg_a_q.channel_trigger_policy && !hot_any_q && !(i_sample.valid && over_l && over_r)
    |=> !hot_any_q;
  endproperty
  a_trig: assert property (p_trig) else $error("both-channel trigger broken");
endmodule

// >>> bench/tb_rlc_level_ctrl.sv
// Self-checking bench for the record level control: register tasks and level scenarios.
// Assumes the design carries its own assertions; samples arrive every cycle when fed.
`include "rlc_map.svh"
module tb_rlc_level_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import rlc_pkg::*;

  logic         I_CORE_CLK = 1'b0;
  logic         I_RST      = 1'b1;
  rlc_reg_req_s req        = '0;
  rlc_sample_s  smp        = '0;
  logic [7:0]   rdata;
  logic [7:0]   gain;
  logic         xtal_run;
  logic         osc_run;
  int           fails      = 0;
  int           checked    = 0;
  logic [15:0]  atk_thr [4] = '{`RLC_DB_0, `RLC_DB_M1, `RLC_DB_M2, `RLC_DB_M4};
  logic [15:0]  rel_thr [4] = '{`RLC_DB_M2, `RLC_DB_M3, `RLC_DB_M4, `RLC_DB_M6};

  // Short millisecond so release periods are 128 to 1024 cycles
  rlc_level_ctrl #(.MS_CYCLES(4)) dut (
    .I_CORE_CLK       (I_CORE_CLK),
    .I_RST            (I_RST),
    .i_req            (req),
    .i_sample         (smp),
    .o_rdata          (rdata),
    .o_gain_reduction (gain),
    .o_crystal_run    (xtal_run),
    .o_rx_osc_run     (osc_run)
  );

  // 200 MHz core clock
  always #2.5 I_CORE_CLK = ~I_CORE_CLK;

  ////////////////////////////////////////////////////////////////////////////
  // Compare helpers, exact and windowed
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  // Window allows for tick phase against the restart write
  task automatic rng(string n, logic [7:0] lo, logic [7:0] hi, logic [7:0] g);
    checked++;
    if ($isunknown(g) || g < lo || g > hi) begin
      fails++;
      $display("unexpected %s: expected %h..%h, seen %h", n, lo, hi, g);
    end
  endtask

  // Register access: strobe for one edge, then one idle edge
  task automatic wr(logic [6:0] a, logic [7:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge I_CORE_CLK);
    req <= '0;
    @(negedge I_CORE_CLK);
  endtask

  task automatic rd(logic [6:0] a, logic [7:0] e, string n);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge I_CORE_CLK);
    req <= '0;
    chk(n, e, rdata);
    @(negedge I_CORE_CLK);
  endtask

  // Quiet inputs first so stale loud samples cannot follow the restart
  task automatic setup(logic [7:0] a, logic [7:0] b);
    smp <= '0;
    wr(`RLC_OFS_CFG_A, a);
    wr(`RLC_OFS_CFG_B, b);
    wr(`RLC_OFS_RESTART, 8'ha5);
  endtask

  task automatic feed(logic [15:0] l, logic [15:0] r, int n);
    smp <= '{left: l, right: r, valid: 1'b1};
    repeat (n) @(negedge I_CORE_CLK);
  endtask

  // Saturate the reduction, then hold a quiet level under new thresholds
  task automatic pump(logic [7:0] a, logic [7:0] b2, logic [15:0] lvl, int q);
    setup(a, 8'h18);
    feed(16'h7000, 16'h7000, 1100);
    wr(`RLC_OFS_CFG_B, b2);
    feed(lvl, lvl, q);
  endtask

  task automatic end_sim();
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(negedge I_CORE_CLK);
    chk("crystal_run", 8'h01, {7'h00, xtal_run});
    chk("rx_osc_run", 8'h01, {7'h00, osc_run});
    I_RST <= 1'b0;
    @(negedge I_CORE_CLK);
    rd(`RLC_OFS_CFG_A, `RLC_RST_CFG, "cfg_a_reset");
    rd(`RLC_OFS_CFG_B, `RLC_RST_CFG, "cfg_b_reset");
    rd(`RLC_OFS_RESTART, `RLC_RST_GAIN, "gain_reset");
    wr(`RLC_OFS_CFG_A, 8'h5a);
    wr(`RLC_OFS_CFG_B, 8'hff);
    wr(7'h10, 8'hff);
    rd(`RLC_OFS_CFG_A, 8'h5a, "cfg_a_rw");
    rd(`RLC_OFS_CFG_B, 8'h7f, "cfg_b_rsvd");
    rd(7'h10, 8'h00, "unmapped");
    // Disabled: loud input, rate 48 kHz, no reduction
    setup(8'h40, 8'h18);
    feed(16'h7fff, 16'h7fff, 80);
    chk("gain_disabled", 8'h00, gain);
    // Attack thresholds and periods, 1 ms is 4 cycles, 4 ms is 16
    for (int c = 0; c < 4; c++) begin
      setup(8'h41, {3'h0, c[1:0], 2'h0, c[0]});
      feed(atk_thr[c] - 16'h0200, atk_thr[c] - 16'h0200, 64);
      chk("gain_under_attack", 8'h00, gain);
      if (c > 0) begin
        setup(8'h41, {3'h0, c[1:0], 2'h0, c[0]});
        feed(atk_thr[c] + 16'h0200, atk_thr[c] + 16'h0200, 64);
        rng("gain_attack", c[0] ? 8'd3 : 8'd15, c[0] ? 8'd5 : 8'd17, gain);
      end
    end
    // One loud channel: either-mode acts, both-mode does not
    setup(8'h41, 8'h18);
    feed(16'h7000, 16'h0000, 40);
    rng("gain_either", 8'd9, 8'd11, gain);
    feed(16'h0000, 16'h0000, 4);
    // Eleven attack ticks have seen a loud sample since the restart
    rd(`RLC_OFS_RESTART, 8'd11, "gain_read");
    wr(`RLC_OFS_RESTART, 8'h00);
    chk("gain_restart", 8'h00, gain);
    setup(8'h43, 8'h18);
    feed(16'h7000, 16'h0000, 40);
    chk("gain_both_one", 8'h00, gain);
    feed(16'h7000, 16'h7000, 40);
    rng("gain_both", 8'd9, 8'd11, gain);
    // No recovery and reserved policy hold the reduction
    pump(8'h41, 8'h00, 16'h0000, 640);
    chk("gain_no_recovery", `RLC_MAX_GAIN, gain);
    pump(8'h4d, 8'h00, 16'h0000, 640);
    chk("gain_rsvd_policy", `RLC_MAX_GAIN, gain);
    // Limited recovery stops at the selected cap
    for (int k = 0; k < 4; k++) begin
      pump({2'b01, k[1:0], 4'h9}, 8'h00, 16'h0000, ((4 << k) + 2) * 128);
      chk("gain_limited", `RLC_MAX_GAIN - 8'((4 << k) - 1), gain);
    end
    // Release periods: 3.5 periods give two or three steps
    for (int s = 0; s < 4; s++) begin
      pump(8'h45, {5'h00, s[1:0], 1'b0}, 16'h0000, (448 << s));
      rng("gain_release", 8'hfc, 8'hfd, gain);
    end
    // Release threshold: just above holds, just below recovers
    for (int r = 0; r < 4; r++) begin
      pump(8'h45, {1'b0, r[1:0], 5'h00}, rel_thr[r] + 16'h0100, 448);
      chk("gain_over_release", `RLC_MAX_GAIN, gain);
      pump(8'h45, {1'b0, r[1:0], 5'h00}, rel_thr[r] - 16'h0100, 448);
      rng("gain_under_release", 8'hfc, 8'hfd, gain);
    end
    end_sim();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (80000) @(posedge I_CORE_CLK);
    fails++;
    end_sim();
  end
endmodule
